//--- hdl/adc_conversion_sequencer.sv
// Conversion sequencer for one 8-bit successive-approximation converter.
// Assumes the analog core returns its result on conv_data when our counter expires,
// and that the trigger pin and on-chip event are asynchronous to sys_clk.
//
// How it works
// - Single mode clears start_stop at conversion end
// - Falling edge on interrupt line per single conversion
// - Continuous mode converts until software clears start_stop
// - Each completion overwrites result with newest value
// - Stopping continuous flow raises same falling-edge interrupt
// - Enabled trigger falling edge or event sets start_stop
// - Continuous mode ignores triggers after the first
// - Triggers while start_stop set are ignored
// - Trigger already active at enable starts at once
// - Power enable cleared at reset and in halt
// - Control write aborts conversion, reinitialises logic
// - Top three control bits select channel 0..7
// - Speed bit picks 78 or 138 clocks
// - Power enable gates the conversion engine and trigger_start
// - Start_stop starts/stops; continuous-mode stop interrupts if enabled
// - Bit 3 trigger enable, bit 1 continuous
// - Instance one at F0h, instance two at F8h
// - Interrupt select routes converter or external pin
`timescale 1ns/1ps
module adc_conversion_sequencer #(
    parameter bit INSTANCE = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Triggers and core state
    input wire logic external_trigger_pin,
    input wire logic onchip_trigger_event,
    input wire logic core_halt,
    // Analog core
    input wire logic [7:0] conv_data,
    output logic analog_power_on,
    output logic sample_active,
    output logic [2:0] channel_select,
    // Interrupt channel
    input wire logic ext_irq_pin,
    output logic irq_channel
);
    //////////////////////////////////////////////////////////////////////////////
    // Address decode
    localparam logic [7:0] IDX_RES = INSTANCE ? adc_seq_pkg::IDX_RESULT_1
                                              : adc_seq_pkg::IDX_RESULT_0;
    localparam logic [7:0] IDX_CTL = INSTANCE ? adc_seq_pkg::IDX_CONTROL_1
                                              : adc_seq_pkg::IDX_CONTROL_0;
    localparam logic [7:0] IDX_INT = INSTANCE ? adc_seq_pkg::IDX_INTSEL_1
                                              : adc_seq_pkg::IDX_INTSEL_0;

    logic [7:0] result_q;
    adc_seq_pkg::control_s ctl_q;
    logic [7:0] intsel_q;
    logic [11:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic aw_have_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
    wire w_take = s_axi_wvalid && !w_have_q && !bvalid_q;
    wire wr_go = aw_have_q && w_have_q && !bvalid_q;
    wire [9:0] wr_idx = awaddr_q[11:2];
    wire wr_aligned = awaddr_q[1:0] == 2'h0;
    wire wr_res = wr_go && wr_aligned && wr_idx == {2'h0, IDX_RES};
    wire wr_ctl = wr_go && wr_aligned && wr_idx == {2'h0, IDX_CTL};
    wire wr_int = wr_go && wr_aligned && wr_idx == {2'h0, IDX_INT};
    wire wr_hit = wr_res || wr_ctl || wr_int;
    wire ctl_write = wr_ctl && wstrb0_q;
    wire ar_take = s_axi_arvalid && !rvalid_q;
    wire [9:0] rd_idx = s_axi_araddr[11:2];
    wire rd_aligned = s_axi_araddr[1:0] == 2'h0;
    wire rd_res = rd_aligned && rd_idx == {2'h0, IDX_RES};
    wire rd_ctl = rd_aligned && rd_idx == {2'h0, IDX_CTL};
    wire rd_int = rd_aligned && rd_idx == {2'h0, IDX_INT};
    wire [7:0] rd_byte = rd_res ? result_q : rd_ctl ? ctl_q : rd_int ? intsel_q : 8'h00;
    wire rd_hit = rd_res || rd_ctl || rd_int;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            awaddr_q <= 12'h000;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Trigger synchronisers and edge detection
    logic [1:0] ext_sync_q;
    logic [1:0] evt_sync_q;
    logic ext_prev_q;
    logic [1:0] pin_sync_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_sync_q <= 2'b11;
            evt_sync_q <= 2'b00;
            pin_sync_q <= 2'b11;
            ext_prev_q <= 1'b1;
        end else begin
            ext_sync_q <= {ext_sync_q[0], external_trigger_pin};
            evt_sync_q <= {evt_sync_q[0], onchip_trigger_event};
            pin_sync_q <= {pin_sync_q[0], ext_irq_pin};
            ext_prev_q <= ext_sync_q[1];
        end
    end

    wire ext_fall = ext_prev_q && !ext_sync_q[1];
    wire ext_low = !ext_sync_q[1];
    wire evt_high = evt_sync_q[1];
    // A trigger already active when enable rises counts at once
    wire trg_rise = ctl_write && wdata_q[adc_seq_pkg::CTL_TRIGGER_ENABLE]
                    && !ctl_q.trigger_enable;
    wire trigger_hit = ctl_q.trigger_enable && (ext_fall || evt_high);
    // Set only from idle: running flow and set start_stop both swallow it
    wire trigger_start = trigger_hit && !ctl_q.start_stop && ctl_q.power_enable;

    //////////////////////////////////////////////////////////////////////////////
    // Conversion engine
    adc_seq_pkg::conv_state_e state_q;
    logic [7:0] cnt_q;
    logic [1:0] irq_low_q;

    wire [7:0] conv_len = ctl_q.speed_select ? adc_seq_pkg::SLOW_CYCLES
                                             : adc_seq_pkg::FAST_CYCLES;
    wire conv_end = state_q == adc_seq_pkg::ST_CONV && cnt_q == 8'h01;
    wire run_ok = ctl_q.start_stop && ctl_q.power_enable;
    wire conv_start = state_q == adc_seq_pkg::ST_IDLE && run_ok;
    wire single_done = conv_end && !ctl_q.cont;
    // Software clear while the flow runs is a stop; only an active flow interrupts
    wire sw_stop = ctl_write && !wdata_q[adc_seq_pkg::CTL_START_STOP]
                   && ctl_q.start_stop && ctl_q.cont;
    wire irq_event = (single_done || sw_stop) && intsel_q[adc_seq_pkg::INTSEL_BIT];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            cnt_q <= 8'h00;
        end else if (ctl_write || core_halt) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            cnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                    if (conv_start) begin
                        state_q <= adc_seq_pkg::ST_CONV;
                        cnt_q <= conv_len;
                    end
                end
                adc_seq_pkg::ST_CONV: begin
                    if (!run_ok) begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                    end else if (conv_end) begin
                        state_q <= adc_seq_pkg::ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                adc_seq_pkg::ST_DONE: begin
                    // Back-to-back in continuous mode, wait in single
                    if (run_ok) begin
                        state_q <= adc_seq_pkg::ST_CONV;
                        cnt_q <= conv_len;
                    end else begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_q <= adc_seq_pkg::CONTROL_RESET;
            intsel_q <= adc_seq_pkg::INTSEL_RESET;
            result_q <= adc_seq_pkg::RESULT_RESET;
        end else begin
            if (ctl_write) begin
                ctl_q <= wdata_q[7:0];
                // Start here covers a trigger already active at enable
                if (trg_rise && !wdata_q[adc_seq_pkg::CTL_START_STOP]
                    && (ext_low || evt_high)) begin
                    ctl_q.start_stop <= 1'b1;
                end
            end else if (trigger_start) begin
                ctl_q.start_stop <= 1'b1;
            end else if (single_done) begin
                ctl_q.start_stop <= 1'b0;
            end
            if (core_halt) begin
                ctl_q.power_enable <= 1'b0;
            end
            if (wr_int && wstrb0_q) begin
                intsel_q <= {7'h00, wdata_q[0]};
            end
            if (conv_end) begin
                result_q <= conv_data;
            end else if (wr_res && wstrb0_q) begin
                result_q <= wdata_q[7:0];
            end
        end
    end

    // Interrupt line idles high; each event drives a short low pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_low_q <= 2'h0;
        end else if (irq_event) begin
            irq_low_q <= adc_seq_pkg::IRQ_LOW_CYCLES;
        end else if (irq_low_q != 2'h0) begin
            irq_low_q <= irq_low_q - 2'h1;
        end
    end

    assign irq_channel = intsel_q[adc_seq_pkg::INTSEL_BIT] ? (irq_low_q == 2'h0)
                                                           : pin_sync_q[1];
    assign analog_power_on = ctl_q.power_enable;
    assign sample_active = state_q == adc_seq_pkg::ST_CONV;
    assign channel_select = ctl_q.channel;

    //////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_single_clear;
        @(posedge sys_clk) disable iff (rst)
        (conv_end && !ctl_q.cont && !ctl_write && !trigger_start) |=> !ctl_q.start_stop;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("start_stop kept after single");

    property p_irq_edge;
        @(posedge sys_clk) disable iff (rst)
        (single_done && intsel_q[0] && !ctl_write) |=> !irq_channel [*2];
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("no low pulse after conversion");

    property p_result;
        @(posedge sys_clk) disable iff (rst)
        conv_end |=> result_q == $past(conv_data);
    endproperty
    a_result: assert property (p_result) else $error("result not updated");

    property p_trigger_set;
        @(posedge sys_clk) disable iff (rst)
        (trigger_start && !ctl_write && !core_halt) |=> ctl_q.start_stop;
    endproperty
    a_trigger_set: assert property (p_trigger_set) else $error("trigger did not start");

    property p_ignore_busy;
        @(posedge sys_clk) disable iff (rst)
        (ctl_q.start_stop && state_q == adc_seq_pkg::ST_CONV && !ctl_write && !conv_end)
        |=> $stable(cnt_q) == 1'b0;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("busy conversion disturbed");

    property p_halt_power;
        @(posedge sys_clk) disable iff (rst)
        core_halt |=> !analog_power_on;
    endproperty
    a_halt_power: assert property (p_halt_power) else $error("power kept during halt");

    property p_abort;
        @(posedge sys_clk) disable iff (rst)
        ctl_write |=> state_q == adc_seq_pkg::ST_IDLE && !sample_active && cnt_q == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("control write did not abort");

    property p_length;
        @(posedge sys_clk) disable iff (rst)
        (conv_start && !ctl_write && !core_halt) |=> cnt_q == conv_len;
    endproperty
    a_length: assert property (p_length) else $error("counter preset wrong");

    property p_power_gate;
        @(posedge sys_clk) disable iff (rst)
        !ctl_q.power_enable |=> !sample_active;
    endproperty
    a_power_gate: assert property (p_power_gate) else $error("converting without power");

    property p_restart;
        @(posedge sys_clk) disable iff (rst)
        (state_q == adc_seq_pkg::ST_DONE && run_ok && !ctl_write && !core_halt)
        |=> sample_active;
    endproperty
    a_restart: assert property (p_restart) else $error("continuous flow did not restart");

    property p_busy_trigger;
        @(posedge sys_clk) disable iff (rst)
        (trigger_hit && ctl_q.start_stop && sample_active && !conv_end && !ctl_write
         && !core_halt) |=> sample_active && cnt_q == $past(cnt_q) - 8'h01;
    endproperty
    a_busy_trigger: assert property (p_busy_trigger) else $error("trigger disturbed busy flow");

    property p_stop_irq;
        @(posedge sys_clk) disable iff (rst)
        (sw_stop && intsel_q[adc_seq_pkg::INTSEL_BIT]) |=> !irq_channel [*2];
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("no low pulse after flow stop");
endmodule

//--- hdl/adc_seq_pkg.sv
// Shared constants and carrier types for the conversion sequencer.
// Assumes a single sys_clk domain and an AXI4-Lite register slave.
package adc_seq_pkg;
    // Printed offsets are not all multiples of four: indices, byte address = 4 * index
    localparam logic [7:0] IDX_RESULT_0 = 8'hF0;
    localparam logic [7:0] IDX_CONTROL_0 = 8'hF1;
    localparam logic [7:0] IDX_INTSEL_0 = 8'hF2;
    localparam logic [7:0] IDX_RESULT_1 = 8'hF8;
    localparam logic [7:0] IDX_CONTROL_1 = 8'hF9;
    localparam logic [7:0] IDX_INTSEL_1 = 8'hFA;
    // Control register field positions
    localparam int CTL_START_STOP = 0;
    localparam int CTL_CONT = 1;
    localparam int CTL_POWER_ENABLE = 2;
    localparam int CTL_TRIGGER_ENABLE = 3;
    localparam int CTL_SPEED_SELECT = 4;
    localparam int CTL_CHAN_LSB = 5;
    localparam int INTSEL_BIT = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] INTSEL_RESET = 8'h01;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // Conversion lengths in internal clocks
    localparam logic [7:0] FAST_CYCLES = 8'h4E;
    localparam logic [7:0] SLOW_CYCLES = 8'h8A;
    // Width of the falling-edge interrupt pulse in clocks
    localparam logic [1:0] IRQ_LOW_CYCLES = 2'h2;

    typedef struct packed {
        logic [2:0] channel;
        logic speed_select;
        logic trigger_enable;
        logic power_enable;
        logic cont;
        logic start_stop;
    } control_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;
endpackage

//--- sim/trigger_partner.sv
// Far-side model: trigger pin, on-chip event, external irq pin, analog result.
// Assumes the bench requests pulses one clock wide, just after a rising edge.
`timescale 1ns/1ps
module trigger_partner (
    // Clock
    input wire logic sys_clk,
    // Requests from the bench
    input wire logic pulse_req,
    input wire logic event_level,
    input wire logic irq_level,
    input wire logic [7:0] sample_value,
    // Toward the sequencer
    output logic external_trigger_pin,
    output logic onchip_trigger_event,
    output logic ext_irq_pin,
    output logic [7:0] conv_data
);
    logic [1:0] low_q = 2'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // Three clocks low, well above the minimum pulse width
    always @(posedge sys_clk) begin
        if (pulse_req && low_q == 2'h0) begin
            low_q <= 2'h3;
        end else if (low_q != 2'h0) begin
            low_q <= low_q - 2'h1;
        end
    end
    // Pin idles high as with a pull-up
    assign external_trigger_pin = (low_q == 2'h0);
    assign onchip_trigger_event = event_level;
    assign ext_irq_pin = irq_level;
    // Analog result held steady while the bench keeps it
    assign conv_data = sample_value;
endmodule

//--- sim/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer, instance 0 mapping.
// Assumes the trigger partner model on the far side.
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
    localparam logic [7:0] CTL = adc_seq_pkg::IDX_CONTROL_0;
    localparam logic [7:0] RES = adc_seq_pkg::IDX_RESULT_0;
    localparam logic [7:0] ISEL = adc_seq_pkg::IDX_INTSEL_0;
    logic sys_clk, rst, core_halt, pulse_req, event_level, irq_level;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic external_trigger_pin, onchip_trigger_event, ext_irq_pin, analog_power_on;
    logic sample_active, irq_channel, irq_prev, act_prev;
    logic [7:0] conv_data, sample;
    logic [2:0] channel_select;
    int fails, checked, ends, falls, act_len, last_len, m_res, m_ctl, e0, f0;
    ////////////////////////////////////////////////////////////////////////////////
    adc_conversion_sequencer dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_trigger_pin, .onchip_trigger_event, .core_halt, .conv_data,
        .analog_power_on, .sample_active, .channel_select, .ext_irq_pin, .irq_channel);
    trigger_partner far_u (.sys_clk, .pulse_req, .event_level, .irq_level,
        .sample_value(sample), .external_trigger_pin, .onchip_trigger_event,
        .ext_irq_pin, .conv_data);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Monitors sample on the falling edge, clear of register updates
    always @(negedge sys_clk) begin
        if (irq_prev && !irq_channel) falls++;
        if (act_prev && !sample_active) begin
            ends++;
            last_len = act_len;
        end
        act_len = sample_active ? act_len + 1 : 0;
        irq_prev = irq_channel;
        act_prev = sample_active;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic hang();
        fails++;
        $display("BAD wait expected done seen timeout");
        tally_and_finish();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Channels released one by one as each is taken; no cycle count assumed
    task automatic bus(input bit wr, input logic [7:0] idx, input logic [7:0] d);
        logic [2:0] pend, t;
        int n;
        pend = wr ? 3'b111 : 3'b101;
        n = 0;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        while (pend != 3'b000) begin
            @(negedge sys_clk);
            t[0] = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
            t[1] = s_axi_wvalid && s_axi_wready;
            t[2] = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
            if (t[2]) begin
                resp = wr ? s_axi_bresp : s_axi_rresp;
                rdat = s_axi_rdata;
            end
            @(posedge sys_clk);
            if (t[0]) s_axi_awvalid <= 1'b0;
            if (t[0]) s_axi_arvalid <= 1'b0;
            if (t[1]) s_axi_wvalid <= 1'b0;
            if (t[2]) s_axi_bready <= 1'b0;
            if (t[2]) s_axi_rready <= 1'b0;
            pend = pend & ~t;
            if (++n > 40) hang();
        end
        // One idle edge so the next call never re-drives a signal just released
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        if (idx == CTL) m_ctl = d;
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp,
                      input logic [1:0] er);
        bus(1'b0, idx, 8'h00);
        chk(nm, rdat, exp);
        chk({nm, "_resp"}, resp, er);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic pulse();
        pulse_req <= 1'b1;
        @(posedge sys_clk);
        pulse_req <= 1'b0;
    endtask
    task automatic wait_ends(input int target);
        int n;
        n = 0;
        while (ends < target) begin
            @(posedge sys_clk);
            if (++n > 2000) hang();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h076E;
        rst = 1'b1;
        {core_halt, pulse_req, event_level, s_axi_awvalid, s_axi_wvalid} = 5'h00;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        irq_level = 1'b1;
        sample = 8'h00;
        {fails, checked, ends, falls, act_len, m_ctl} = '0;
        irq_prev = 1'b1;
        act_prev = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        chk("reset_power", analog_power_on, 0);
        rd("ctl_reset", CTL, adc_seq_pkg::CONTROL_RESET, 2'h0);
        rd("isel_reset", ISEL, 32'h1, 2'h0);
        rd("res_reset", RES, 32'h0, 2'h0);
        rd("unit_one", adc_seq_pkg::IDX_RESULT_1, 32'h0, 2'h2);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(CTL, {c[2:0], 5'h04});
            cyc(3);
            chk("channel", channel_select, c);
            chk("power_on", analog_power_on, 1);
        end
        // Bias settling time before the first conversion
        cyc(12000);
        $display("test channels done");
        for (int s = 0; s < 2; s++) begin
            sample <= next_rand();
            e0 = ends;
            f0 = falls;
            // Fast timing only exercised here for its length, not its clock limit
            wr(CTL, {3'h2, s[0], 4'h5});
            wait_ends(e0 + 1);
            cyc(5);
            m_res = sample;
            f0 = falls - f0;
            e0 = s ? int'(adc_seq_pkg::SLOW_CYCLES) : int'(adc_seq_pkg::FAST_CYCLES);
            chk("length", last_len >= e0 && last_len <= e0 + 2, 1);
            rd("single_res", RES, m_res, 2'h0);
            rd("single_clear", CTL, m_ctl & 8'hFE, 2'h0);
            chk("single_irq", f0, 1);
        end
        $display("test single done");
        sample <= next_rand();
        e0 = ends;
        f0 = falls;
        wr(CTL, 8'h0E);
        pulse();
        wait_ends(e0 + 1);
        pulse();
        sample <= next_rand();
        wait_ends(e0 + 3);
        m_res = sample;
        rd("flow_res", RES, m_res, 2'h0);
        rd("flow_run", CTL, 8'h0F, 2'h0);
        chk("flow_quiet", falls - f0, 0);
        wr(CTL, 8'h04);
        cyc(10);
        chk("stop_irq", falls - f0, 1);
        chk("stopped", sample_active, 0);
        $display("test continuous done");
        wr(ISEL, 8'h00);
        wr(CTL, 8'h15);
        cyc(20);
        sample <= ~sample;
        wr(CTL, 8'h04);
        cyc(200);
        rd("abort_res", RES, m_res, 2'h0);
        chk("abort_idle", sample_active, 0);
        wr(ISEL, 8'h01);
        $display("test abort done");
        e0 = ends;
        wr(CTL, 8'h0C);
        pulse();
        cyc(30);
        pulse();
        wait_ends(e0 + 1);
        cyc(150);
        chk("one_conv", ends - e0, 1);
        rd("trig_done", CTL, 8'h0C, 2'h0);
        wr(CTL, 8'h04);
        e0 = ends;
        event_level <= 1'b1;
        cyc(4);
        wr(CTL, 8'h0C);
        event_level <= 1'b0;
        wait_ends(e0 + 1);
        chk("armed_start", ends - e0, 1);
        $display("test trigger done");
        core_halt <= 1'b1;
        cyc(3);
        chk("halt_power", analog_power_on, 0);
        core_halt <= 1'b0;
        rd("halt_ctl", CTL, 8'h08, 2'h0);
        wr(ISEL, 8'h00);
        irq_level <= 1'b0;
        cyc(6);
        chk("route_low", irq_channel, 0);
        irq_level <= 1'b1;
        cyc(6);
        chk("route_high", irq_channel, 1);
        rd("isel_back", ISEL, 32'h0, 2'h0);
        $display("test halt and routing done");
        tally_and_finish();
    end
endmodule
